// ===== hdl/paf_map.svh
`ifndef PAF_MAP_SVH
`define PAF_MAP_SVH
// Port indices
`define PAF_PA 0
`define PAF_PB 1
`define PAF_PC 2
`define PAF_PD 3
`define PAF_PE 4
`define PAF_NPORT 5
`define PAF_NSEL 3
// Register byte offsets
`define PAF_OFF_SEL1_A 8'h00
`define PAF_OFF_SEL1_B 8'h04
`define PAF_OFF_SEL1_C 8'h08
`define PAF_OFF_SEL2_A 8'h0C
`define PAF_OFF_SEL2_B 8'h10
`define PAF_OFF_SEL2_C 8'h14
`define PAF_OFF_AFEN_A 8'h18
`define PAF_OFF_AFEN_B 8'h1C
`define PAF_OFF_AFEN_C 8'h20
`define PAF_OFF_AFEN_D 8'h24
`define PAF_OFF_AFEN_E 8'h28
`define PAF_OFF_CFG    8'h2C
`define PAF_OFF_LED    8'h30
`define PAF_OFF_RSVD   8'h34
// Reset values
`define PAF_RST_BYTE   8'h00
`define PAF_RST_EN_D   8'h01
`define PAF_RST_LED    16'h0000
`define PAF_RST_WORD   32'h0000_0000
// Config field
`define PAF_CFG_PKG28  0
// Bus responses
`define PAF_RESP_OKAY  2'b00
`define PAF_RESP_SLVE  2'b10
// Valid selection masks: OK0 = code 0 usable, OK1 = code 1 usable
`define PAF_OK0_A      8'hFF
`define PAF_OK1_A_20   8'hF0
`define PAF_OK1_A_28   8'hC0
`define PAF_OK0_B      8'h08
`define PAF_OK1_B_20   8'h0F
`define PAF_OK1_B_28   8'h3F
`define PAF_OK0_C_20   8'h08
`define PAF_OK0_C_28   8'hFA
`define PAF_OK1_C_20   8'h0F
`define PAF_OK1_C_28   8'hFF
`define PAF_OK0_D      8'h01
`define PAF_OK0_E      8'h00
`define PAF_NONE       8'h00
// Named pins
`define PAF_B_CLK_PIN  3
`define PAF_B_VREF_PIN 5
`define PAF_C_CMP_PIN  3
`define PAF_C_LED_PIN  4
`define PAF_A_SCL_PIN  6
`define PAF_A_DE_PIN   2
`define PAF_A_T0_PIN   0
`define PAF_D_RST_PIN  0
`endif

// ===== hdl/paf_pin_route.sv
`timescale 1ns/1ps
// Per-port mode decode, pure combinational
module paf_pin_route (
  paf_route_if.route rt
);
  // Enable off keeps the pin on general I/O
  assign rt.gpio = ~rt.en;
  // Code 0 live only where usable on this port
  assign rt.act0 = rt.en & ~rt.sel & rt.ok0;
  // Code 1 live only where usable on this port
  assign rt.act1 = rt.en & rt.sel & rt.ok1;
  // Enabled but nothing usable behind the code
  assign rt.rsv  = rt.en & ~((~rt.sel & rt.ok0) | (rt.sel & rt.ok1));
endmodule

// ===== hdl/paf_pkg.sv
`include "paf_map.svh"
package paf_pkg;
  typedef logic [7:0] paf_byte_t;
  typedef logic [`PAF_NPORT-1:0][7:0] paf_ports_t;
  typedef enum logic {PAF_PKG_20, PAF_PKG_28} paf_pkg_t;
endpackage

// ===== hdl/paf_route_if.sv
`timescale 1ns/1ps
// Carries one port's configuration into the router and the pin modes back
interface paf_route_if;
  logic [7:0] sel;   // Selection byte
  logic [7:0] en;    // Alternate enable
  logic [7:0] ok0;   // Code 0 usable
  logic [7:0] ok1;   // Code 1 usable
  logic [7:0] act0;  // Code 0 function live
  logic [7:0] act1;  // Code 1 function live
  logic [7:0] gpio;  // Plain I/O
  logic [7:0] rsv;   // Enabled on a reserved code
  modport route (input sel, en, ok0, ok1, output act0, act1, gpio, rsv);
  modport cfg   (output sel, en, ok0, ok1, input act0, act1, gpio, rsv);
endinterface

// ===== hdl/paf_top.sv
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "paf_map.svh"
// Notes on behaviour
// - Port B selection picks analog or clock
// - 28-pin B4/B5 code 1: analog, reference
// - 20-pin port C: analog/LED_CURRENT_DRIVE, pin3 comparator
// - 28-pin A0/A1 timer0, A6/A7 timer1 or bus
// - 28-pin A2-A5 serial on code 0 only
// - Second set register stored, never steers
// - Function live only with its enable set
// - Port D enable connects single function; port E enable connects none
// - Alternate pins take direction from peripheral
// - LED_CURRENT_DRIVE mode via code 1, level registers
module paf_top
  import paf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire paf_ports_t  pin_in,
  output paf_ports_t       pin_out,
  output paf_ports_t       pin_oe,
  input  wire paf_ports_t  gpio_out,
  input  wire paf_ports_t  gpio_dir,
  output paf_ports_t       gpio_in,
  input  wire paf_ports_t  alt0_out,
  input  wire paf_ports_t  alt0_oe,
  output paf_ports_t       alt0_in,
  input  wire paf_ports_t  alt1_out,
  input  wire paf_ports_t  alt1_oe,
  output paf_ports_t       alt1_in,
  output logic [7:0]       led_en,
  output logic [15:0]      led_level
);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration state
  logic [`PAF_NSEL-1:0][7:0]  sel1_r;   // First set, steers routing
  logic [`PAF_NSEL-1:0][7:0]  sel2_r;   // Second set, storage only
  paf_ports_t                 afen_r;   // Per-pin alternate enable
  paf_pkg_t                   pkg_r;    // Package variant
  logic [15:0]                led_r;    // Two level bits per port C pin
  paf_ports_t                 act0_w;   // Code 0 live per pin
  paf_ports_t                 act1_w;   // Code 1 live per pin
  paf_ports_t                 rsv_w;    // Reserved hits per pin

  // Write channel state
  logic                       aw_hold_r;
  logic [7:0]                 awaddr_r;
  logic                       w_hold_r;
  logic [31:0]                wdata_r;
  logic [3:0]                 wstrb_r;
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;
  logic                       do_wr;
  // Read channel state
  logic                       rvalid_r;
  logic [31:0]                rdata_r;
  logic [1:0]                 rresp_r;
  logic [31:0]                rd_data;
  logic                       rd_err;

  //////////////////////////////////////////////////////////////////////////////
  // Address and data accepted in either order, one write at a time
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready  = !w_hold_r && !bvalid_r;
  assign do_wr   = aw_hold_r && w_hold_r && !bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  // Address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= `PAF_RST_BYTE;
    end else if (awvalid && awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= awaddr;
    end else if (do_wr) begin
      aw_hold_r <= 1'b0;
    end
  end

  // Data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r  <= `PAF_RST_WORD;
      wstrb_r  <= 4'h0;
    end else if (wvalid && wready) begin
      w_hold_r <= 1'b1;
      wdata_r  <= wdata;
      wstrb_r  <= wstrb;
    end else if (do_wr) begin
      w_hold_r <= 1'b0;
    end
  end

  // Byte lane merge, only lanes the strobe names change
  function automatic paf_byte_t lane(paf_byte_t old, logic stb, paf_byte_t nw);
    lane = stb ? nw : old;
  endfunction

  // Register writes; second set kept but unread by routing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel1_r <= '0;
      sel2_r <= '0;
      afen_r <= '0;
      afen_r[`PAF_PD] <= `PAF_RST_EN_D;  // Pin D0 wakes as reset
      pkg_r  <= PAF_PKG_20;
      led_r  <= `PAF_RST_LED;
      bresp_r <= `PAF_RESP_OKAY;
    end else if (do_wr) begin
      bresp_r <= `PAF_RESP_OKAY;
      if (awaddr_r == `PAF_OFF_SEL1_A) begin
        sel1_r[`PAF_PA] <= lane(sel1_r[`PAF_PA], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_SEL1_B) begin
        sel1_r[`PAF_PB] <= lane(sel1_r[`PAF_PB], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_SEL1_C) begin
        sel1_r[`PAF_PC] <= lane(sel1_r[`PAF_PC], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_SEL2_A) begin
        sel2_r[`PAF_PA] <= lane(sel2_r[`PAF_PA], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_SEL2_B) begin
        sel2_r[`PAF_PB] <= lane(sel2_r[`PAF_PB], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_SEL2_C) begin
        sel2_r[`PAF_PC] <= lane(sel2_r[`PAF_PC], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_AFEN_A) begin
        afen_r[`PAF_PA] <= lane(afen_r[`PAF_PA], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_AFEN_B) begin
        afen_r[`PAF_PB] <= lane(afen_r[`PAF_PB], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_AFEN_C) begin
        afen_r[`PAF_PC] <= lane(afen_r[`PAF_PC], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_AFEN_D) begin
        afen_r[`PAF_PD] <= lane(afen_r[`PAF_PD], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_AFEN_E) begin
        afen_r[`PAF_PE] <= lane(afen_r[`PAF_PE], wstrb_r[0], wdata_r[7:0]);
      end else if (awaddr_r == `PAF_OFF_CFG) begin
        if (wstrb_r[0]) begin
          pkg_r <= paf_pkg_t'(wdata_r[`PAF_CFG_PKG28]);
        end
      end else if (awaddr_r == `PAF_OFF_LED) begin
        led_r[7:0]  <= lane(led_r[7:0], wstrb_r[0], wdata_r[7:0]);
        led_r[15:8] <= lane(led_r[15:8], wstrb_r[1], wdata_r[15:8]);
      end else if (awaddr_r == `PAF_OFF_RSVD) begin
        bresp_r <= `PAF_RESP_OKAY;  // Status is read-only, write dropped
      end else begin
        bresp_r <= `PAF_RESP_SLVE;  // Unmapped
      end
    end
  end

  // Write response, held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read decode; bits above the register width read as zero
  always_comb begin
    rd_data = `PAF_RST_WORD;
    rd_err  = 1'b0;
    if (araddr == `PAF_OFF_SEL1_A) begin
      rd_data[7:0] = sel1_r[`PAF_PA];
    end else if (araddr == `PAF_OFF_SEL1_B) begin
      rd_data[7:0] = sel1_r[`PAF_PB];
    end else if (araddr == `PAF_OFF_SEL1_C) begin
      rd_data[7:0] = sel1_r[`PAF_PC];
    end else if (araddr == `PAF_OFF_SEL2_A) begin
      rd_data[7:0] = sel2_r[`PAF_PA];
    end else if (araddr == `PAF_OFF_SEL2_B) begin
      rd_data[7:0] = sel2_r[`PAF_PB];
    end else if (araddr == `PAF_OFF_SEL2_C) begin
      rd_data[7:0] = sel2_r[`PAF_PC];
    end else if (araddr == `PAF_OFF_AFEN_A) begin
      rd_data[7:0] = afen_r[`PAF_PA];
    end else if (araddr == `PAF_OFF_AFEN_B) begin
      rd_data[7:0] = afen_r[`PAF_PB];
    end else if (araddr == `PAF_OFF_AFEN_C) begin
      rd_data[7:0] = afen_r[`PAF_PC];
    end else if (araddr == `PAF_OFF_AFEN_D) begin
      rd_data[7:0] = afen_r[`PAF_PD];
    end else if (araddr == `PAF_OFF_AFEN_E) begin
      rd_data[7:0] = afen_r[`PAF_PE];
    end else if (araddr == `PAF_OFF_CFG) begin
      rd_data[`PAF_CFG_PKG28] = (pkg_r == PAF_PKG_28);
    end else if (araddr == `PAF_OFF_LED) begin
      rd_data[15:0] = led_r;
    end else if (araddr == `PAF_OFF_RSVD) begin
      rd_data[23:0] = {rsv_w[`PAF_PC], rsv_w[`PAF_PB], rsv_w[`PAF_PA]};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Read answer registered on the same edge that takes the address
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= `PAF_RST_WORD;
      rresp_r  <= `PAF_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data;
      rresp_r  <= rd_err ? `PAF_RESP_SLVE : `PAF_RESP_OKAY;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Usable codes per port and package; returns {ok1, ok0}
  function automatic logic [15:0] ok_masks(int p, paf_pkg_t pk);
    logic big;
    big = (pk == PAF_PKG_28);
    case (p)
      `PAF_PA: ok_masks = {big ? `PAF_OK1_A_28 : `PAF_OK1_A_20, `PAF_OK0_A};
      `PAF_PB: ok_masks = {big ? `PAF_OK1_B_28 : `PAF_OK1_B_20, `PAF_OK0_B};
      `PAF_PC: ok_masks = {big ? `PAF_OK1_C_28 : `PAF_OK1_C_20,
                           big ? `PAF_OK0_C_28 : `PAF_OK0_C_20};
      `PAF_PD: ok_masks = {`PAF_NONE, `PAF_OK0_D};
      default: ok_masks = {`PAF_NONE, `PAF_OK0_E};
    endcase
  endfunction

  // One router and one pin stage per port
  for (genvar p = 0; p < `PAF_NPORT; p++) begin : g_port
    paf_route_if rif();
    logic [15:0] okm;
    logic [7:0]  out_q, oe_q, gin_q, a0_q, a1_q;

    assign okm = ok_masks(p, pkg_r);
    // Ports without set registers see code 0
    if (p < `PAF_NSEL) begin : g_sel
      assign rif.sel = sel1_r[p];
    end else begin : g_nosel
      assign rif.sel = `PAF_NONE;
    end
    assign rif.en  = afen_r[p];
    assign rif.ok0 = okm[7:0];
    assign rif.ok1 = okm[15:8];

    paf_pin_route u_route (
      .rt (rif.route)
    );

    assign act0_w[p] = rif.act0;
    assign act1_w[p] = rif.act1;
    assign rsv_w[p]  = rif.rsv;

    // Pin drive: GPIO direction, or peripheral direction, or off
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_q <= `PAF_NONE;
        oe_q  <= `PAF_NONE;
      end else begin
        out_q <= (rif.gpio & gpio_out[p]) | (rif.act0 & alt0_out[p]) |
                 (rif.act1 & alt1_out[p]);
        oe_q  <= (rif.gpio & gpio_dir[p]) | (rif.act0 & alt0_oe[p]) |
                 (rif.act1 & alt1_oe[p]);
      end
    end

    // Pin sampling, peripherals see only their own live pins
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        gin_q <= `PAF_NONE;
        a0_q  <= `PAF_NONE;
        a1_q  <= `PAF_NONE;
      end else begin
        gin_q <= pin_in[p];
        a0_q  <= pin_in[p] & rif.act0;
        a1_q  <= pin_in[p] & rif.act1;
      end
    end

    assign pin_out[p] = out_q;
    assign pin_oe[p]  = oe_q;
    assign gpio_in[p] = gin_q;
    assign alt0_in[p] = a0_q;
    assign alt1_in[p] = a1_q;
  end

  // LED_CURRENT_DRIVE mode on port C code 1, current level always from its register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_en    <= `PAF_NONE;
      led_level <= `PAF_RST_LED;
    end else begin
      led_en    <= act1_w[`PAF_PC];
      led_level <= led_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Checks armed one edge after reset lifts; the first attempt would
  // otherwise hold reset-cleared flops against live inputs
  logic chk_live_r;  // Low through reset and its release edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_live_r <= 1'b0;
    end else begin
      chk_live_r <= 1'b1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !chk_live_r);

  // Clock input on B3 when code 0
  property p_b3_clk;
    afen_r[`PAF_PB][`PAF_B_CLK_PIN] && !sel1_r[`PAF_PB][`PAF_B_CLK_PIN]
      |=> alt0_in[`PAF_PB][`PAF_B_CLK_PIN] == $past(pin_in[`PAF_PB][`PAF_B_CLK_PIN]);
  endproperty
  a_b3_clk: assert property (p_b3_clk) else $error("B3 clock not routed");

  sequence s_b5_pick;
    afen_r[`PAF_PB][`PAF_B_VREF_PIN] && sel1_r[`PAF_PB][`PAF_B_VREF_PIN];
  endsequence
  property p_b5_vref;
    s_b5_pick |=> pin_oe[`PAF_PB][`PAF_B_VREF_PIN] ==
      ($past(pkg_r) == PAF_PKG_28 && $past(alt1_oe[`PAF_PB][`PAF_B_VREF_PIN]));
  endproperty
  a_b5_vref: assert property (p_b5_vref) else $error("B5 reference wrong");

  property p_c3_cmp;
    pkg_r == PAF_PKG_20 && afen_r[`PAF_PC][`PAF_C_CMP_PIN]
      |=> led_en[`PAF_C_CMP_PIN] == $past(sel1_r[`PAF_PC][`PAF_C_CMP_PIN]);
  endproperty
  a_c3_cmp: assert property (p_c3_cmp) else $error("C3 mode wrong");

  property p_a6_bus;
    pkg_r == PAF_PKG_28 && afen_r[`PAF_PA][`PAF_A_SCL_PIN] &&
      sel1_r[`PAF_PA][`PAF_A_SCL_PIN]
      |=> pin_oe[`PAF_PA][`PAF_A_SCL_PIN] == $past(alt1_oe[`PAF_PA][`PAF_A_SCL_PIN]);
  endproperty
  a_a6_bus: assert property (p_a6_bus) else $error("A6 bus clock wrong");

  property p_a2_rsv;
    pkg_r == PAF_PKG_28 && afen_r[`PAF_PA][`PAF_A_DE_PIN] &&
      sel1_r[`PAF_PA][`PAF_A_DE_PIN]
      |=> !pin_oe[`PAF_PA][`PAF_A_DE_PIN] && !alt0_in[`PAF_PA][`PAF_A_DE_PIN];
  endproperty
  a_a2_rsv: assert property (p_a2_rsv) else $error("A2 reserved drove");

  property p_sel2_idle;
    $changed(sel2_r) && $stable(sel1_r) && $stable(afen_r) && $stable(pkg_r)
      |-> $stable(act0_w) && $stable(act1_w);
  endproperty
  a_sel2_idle: assert property (p_sel2_idle) else $error("second set steered");

  property p_gpio;
    !afen_r[`PAF_PA][`PAF_A_T0_PIN]
      |=> pin_oe[`PAF_PA][`PAF_A_T0_PIN] == $past(gpio_dir[`PAF_PA][`PAF_A_T0_PIN]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("disabled pin not GPIO");

  property p_d0_rst;
    afen_r[`PAF_PD][`PAF_D_RST_PIN]
      |=> alt0_in[`PAF_PD][`PAF_D_RST_PIN] == $past(pin_in[`PAF_PD][`PAF_D_RST_PIN]);
  endproperty
  a_d0_rst: assert property (p_d0_rst) else $error("D0 reset not routed");

  property p_a0_dir;
    afen_r[`PAF_PA][`PAF_A_T0_PIN] && !sel1_r[`PAF_PA][`PAF_A_T0_PIN]
      |=> pin_oe[`PAF_PA][`PAF_A_T0_PIN] == $past(alt0_oe[`PAF_PA][`PAF_A_T0_PIN]);
  endproperty
  a_a0_dir: assert property (p_a0_dir) else $error("A0 direction wrong");

  property p_c4_led;
    pkg_r == PAF_PKG_28 && afen_r[`PAF_PC][`PAF_C_LED_PIN] &&
      sel1_r[`PAF_PC][`PAF_C_LED_PIN]
      |=> led_en[`PAF_C_LED_PIN] && led_level == $past(led_r);
  endproperty
  a_c4_led: assert property (p_c4_led) else $error("C4 LED_CURRENT_DRIVE not set");

  property p_rsv_off;
    rsv_w[`PAF_PC] != `PAF_NONE
      |=> (pin_oe[`PAF_PC] & $past(rsv_w[`PAF_PC])) == `PAF_NONE;
  endproperty
  a_rsv_off: assert property (p_rsv_off) else $error("reserved pin drove");

endmodule

// ===== tb/paf_periph_model.sv
`timescale 1ns/1ps
`include "paf_map.svh"
// Far side of the mux: on-chip peripherals plus board pads
module paf_periph_model
  import paf_pkg::*;
(
  input  wire paf_ports_t pin_out,
  input  wire paf_ports_t pin_oe,
  output paf_ports_t      pin_in,
  output paf_ports_t      alt0_out,
  output paf_ports_t      alt0_oe,
  output paf_ports_t      alt1_out,
  output paf_ports_t      alt1_oe
);
  ////////////////////////////////////////////////////////////////
  // Pad level: own drive, else the board pull-up, never a stale value
  always_comb begin
    for (int p = 0; p < `PAF_NPORT; p++) begin
      pin_in[p] = pin_out[p] | ~pin_oe[p];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Peripheral drive: distinct per port and per code, so a swap shows
  always_comb begin
    for (int p = 0; p < `PAF_NPORT; p++) begin
      alt0_out[p] = 8'h96 ^ 8'(p);
      alt0_oe[p]  = 8'hFF ^ 8'(p);       // Mostly driving, unlike GPIO
      alt1_out[p] = 8'h69 ^ 8'(p);
      alt1_oe[p]  = 8'hFF ^ 8'(p << 5);
    end
  end
endmodule

// ===== tb/port_alt_function_select_tb.sv
`timescale 1ns/1ps
`include "paf_map.svh"
// Self-checking bench for the pin mux
module port_alt_function_select_tb
  import paf_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  paf_ports_t  pin_in, pin_out, pin_oe, gpio_out, gpio_dir, gpio_in;
  paf_ports_t  alt0_out, alt0_oe, alt0_in, alt1_out, alt1_oe, alt1_in;
  logic [7:0]  led_en;
  logic [15:0] led_level;
  int          error_cnt, checks, cyc;
  logic [7:0]  m_sel [3];  // Mirror of selection bytes A..C
  logic [7:0]  m_en [5];   // Mirror of enables A..E
  logic        m_pkg28;    // Mirror of package choice

  paf_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .gpio_out(gpio_out),
    .gpio_dir(gpio_dir), .gpio_in(gpio_in), .alt0_out(alt0_out), .alt0_oe(alt0_oe),
    .alt0_in(alt0_in), .alt1_out(alt1_out), .alt1_oe(alt1_oe), .alt1_in(alt1_in),
    .led_en(led_en), .led_level(led_level));

  paf_periph_model peer (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .alt0_out(alt0_out), .alt0_oe(alt0_oe), .alt1_out(alt1_out), .alt1_oe(alt1_oe));

  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin   // Whole run needs well under this
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Reporting
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Bus cycles: sample ready at the falling edge, act at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd, ta, tw;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(negedge aclk); while (!bvalid);
    cmp(32'(bresp), 32'(r));
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    cmp(rdata, d);
    cmp(32'(rresp), 32'(r));
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Port setup; ports D and E own no selection byte
  task automatic cfg(input int p, input logic [7:0] s, input logic [7:0] e);
    if (p < 3) begin
      m_sel[p] = s;
      wr(`PAF_OFF_SEL1_A + 8'(4 * p), {24'h0, s}, `PAF_RESP_OKAY);
    end
    m_en[p] = e;
    wr(`PAF_OFF_AFEN_A + 8'(4 * p), {24'h0, e}, `PAF_RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////
  // Pin expectation from the mapping tables, all five ports
  task automatic check_pins();
    logic [7:0] o0, o1, s, l0, l1, g, eo, ev;
    repeat (4) @(negedge aclk);
    for (int p = 0; p < 5; p++) begin
      case (p)
        0: begin
          o0 = 8'hFF;
          o1 = m_pkg28 ? 8'hC0 : 8'hF0;
        end
        1: begin
          o0 = 8'h08;
          o1 = m_pkg28 ? 8'h3F : 8'h0F;
        end
        2: begin
          o0 = m_pkg28 ? 8'hFA : 8'h08;
          o1 = m_pkg28 ? 8'hFF : 8'h0F;
        end
        3: begin
          o0 = 8'h01;        // Reset function only
          o1 = 8'h00;
        end
        default: begin
          o0 = 8'h00;        // No port E pins in these packages
          o1 = 8'h00;
        end
      endcase
      s  = (p < 3) ? m_sel[p] : 8'h00;
      l0 = m_en[p] & ~s & o0;
      l1 = m_en[p] & s & o1;
      g  = ~m_en[p];
      eo = (g & gpio_dir[p]) | (l0 & alt0_oe[p]) | (l1 & alt1_oe[p]);
      ev = (g & gpio_out[p]) | (l0 & alt0_out[p]) | (l1 & alt1_out[p]);
      cmp(32'(pin_oe[p]), 32'(eo));
      cmp(32'(pin_out[p] & eo), 32'(ev & eo));
      cmp(32'(alt0_in[p]), 32'(pin_in[p] & l0));
      cmp(32'(alt1_in[p]), 32'(pin_in[p] & l1));
      cmp(32'(gpio_in[p]), 32'(pin_in[p]));
    end
    cmp(32'(led_en), 32'(m_en[2] & m_sel[2] & (m_pkg28 ? 8'hFF : 8'h0F)));
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    for (int a = 0; a <= 8'h34; a += 4) begin
      rd(8'(a), (a == 8'h24) ? 32'h0000_0001 : 32'h0000_0000, `PAF_RESP_OKAY);
    end
    rd(8'h38, 32'h0000_0000, `PAF_RESP_SLVE);
    wr(8'h38, 32'hFFFF_FFFF, `PAF_RESP_SLVE);
    check_pins();
  endtask

  task automatic t_port_b20();
    cfg(1, 8'h0A, 8'h0F);
    check_pins();
    cfg(1, 8'h05, 8'h0E);
    check_pins();
    cfg(1, 8'h00, 8'h00);
  endtask

  task automatic t_port_c20();
    cfg(2, 8'h07, 8'h0F);
    check_pins();
    cfg(2, 8'h08, 8'hFF);
    check_pins();
    wr(`PAF_OFF_LED, 32'hFFFF_FFFF, `PAF_RESP_OKAY);
    rd(`PAF_OFF_LED, 32'h0000_FFFF, `PAF_RESP_OKAY);
    cmp(32'(led_level), 32'h0000_FFFF);
    wr(`PAF_OFF_LED, 32'h0000_1B1B, `PAF_RESP_OKAY);
    @(negedge aclk);  // Level flop follows the register one edge later
    cmp(32'(led_level), 32'h0000_1B1B);
  endtask

  task automatic t_pkg28();
    m_pkg28 = 1'b1;
    wr(`PAF_OFF_CFG, 32'h0000_0001, `PAF_RESP_OKAY);
    cfg(0, 8'hC0, 8'hFF);
    check_pins();
    cfg(0, 8'h3F, 8'hFF);
    check_pins();
    cfg(1, 8'h30, 8'h30);
    check_pins();
    cfg(1, 8'h00, 8'h30);
    check_pins();
    cfg(2, 8'hF5, 8'hFF);
    check_pins();
    m_pkg28 = 1'b0;
    wr(`PAF_OFF_CFG, 32'h0000_0000, `PAF_RESP_OKAY);
    check_pins();
    cfg(0, 8'h00, 8'h00);
  endtask

  // Second set register: kept and readable, but never steers
  task automatic t_set_two();
    cfg(0, 8'hF0, 8'hFF);
    for (int a = 0; a < 3; a++) begin
      wr(`PAF_OFF_SEL2_A + 8'(4 * a), 32'h1234_56FF, `PAF_RESP_OKAY);
      rd(`PAF_OFF_SEL2_A + 8'(4 * a), 32'h0000_00FF, `PAF_RESP_OKAY);
    end
    check_pins();
    cfg(0, 8'h00, 8'h00);
  endtask

  task automatic t_port_de();
    cfg(3, 8'h00, 8'h00);
    check_pins();
    cfg(3, 8'h00, 8'h01);
    cfg(4, 8'h00, 8'hFF);
    check_pins();
    wr(`PAF_OFF_RSVD, 32'hFFFF_FFFF, `PAF_RESP_OKAY);
    // Status untouched by the write: C reserved F2, B reserved 30
    rd(`PAF_OFF_RSVD, 32'h00F2_3000, `PAF_RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    aresetn  = 1'b0;
    awvalid  = 1'b0;
    wvalid   = 1'b0;
    bready   = 1'b0;
    arvalid  = 1'b0;
    rready   = 1'b0;
    awaddr   = 8'h00;
    araddr   = 8'h00;
    wdata    = 32'h0000_0000;
    wstrb    = 4'hF;
    gpio_out = {5{8'hA5}};
    gpio_dir = {5{8'h0F}};  // Differs from peripheral enables
    m_sel    = '{8'h00, 8'h00, 8'h00};
    m_en     = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    m_pkg28  = 1'b0;
    error_cnt = 0;
    checks   = 0;
    cyc      = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_port_b20();
    t_port_c20();
    t_pkg28();
    t_set_two();
    t_port_de();
    complete_run();
  end
endmodule
